// >>> ccr_regs.sv
// comparator control and mode registers on the special function register bus
`timescale 1ns/1ps
// Summary of operation
// - control bit 7 enables the comparator.
// - control bit 6 reads the live synchronised comparator result while enabled, and zero while disabled.
// - control bit 5 sets on a rising result edge, sticky until cleared.
// - control bit 4 sets on a falling result edge, sticky until cleared.
// - control bits 3-2 select positive hysteresis, driven to the analog side.
// - control bits 1-0 select negative hysteresis, driven to the analog side.
// - control registers decode at 0x88, comparator chosen by page 1, 2, 3.
// - mode registers decode at 0x89, comparator chosen by page 1, 2, 3.
// - mode bit 5 enables the rising-edge interrupt.
// - mode bit 4 enables the falling-edge interrupt; both may be on.
// - mode bits 1-0 select response time; mode resets to 0x02.
// - mode bits 7-6 and 3-2 read zero and ignore writes.
// - interrupt asserts only with edge enable and extended enable both set.
// - a disabled comparator drives its crossbar output low.
module ccr_regs (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_page,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	input  wire logic [2:0]  cmp_raw,
	input  wire logic [2:0]  cmp_irq_global_en,
	output logic      [2:0]  cmp_enable,
	output logic      [5:0]  pos_hysteresis_sel,
	output logic      [5:0]  neg_hysteresis_sel,
	output logic      [5:0]  response_time_sel,
	output logic      [2:0]  cmp_pin_out,
	output logic      [2:0]  cmp_irq
);
	logic [7:0] ctrl_q [3];
	logic [7:0] mode_q [3];
	logic [2:0] res_sync;
	logic [2:0] res_prev_q;
	logic [2:0] sel_idx;
	logic [2:0] ctrl_sel;
	logic [2:0] mode_sel;
	logic [2:0] rise_evt;
	logic [2:0] fall_evt;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_parts [3];

	// page 1..3 maps to comparator 0..2
	function automatic logic [2:0] page_onehot(input logic [7:0] page);
		logic [2:0] r;
		r = 3'h0;
		if (page == ccr_pkg::PAGE_CMP0) r = 3'h1;
		if (page == ccr_pkg::PAGE_CMP0 + 8'h01) r = 3'h2;
		if (page == ccr_pkg::PAGE_CMP0 + 8'h02) r = 3'h4;
		return r;
	endfunction : page_onehot

	assign sel_idx  = page_onehot(sfr_page);
	assign ctrl_sel = (sfr_addr == ccr_pkg::CTRL_ADDR) ? sel_idx : 3'h0;
	assign mode_sel = (sfr_addr == ccr_pkg::MODE_ADDR) ? sel_idx : 3'h0;
	assign sfr_hit  = |{ctrl_sel, mode_sel};

	genvar g;
	generate
		for (g = 0; g < ccr_pkg::NUM_CMP; g++) begin : g_cmp
			logic [7:0] ctrl_rd;
			logic       rise_d;
			logic       fall_d;

			ccr_sync u_sync (
				.mclk    (mclk),
				.reset_n (reset_n),
				.async_in(cmp_raw[g]),
				.level_q (res_sync[g])
			);

			// edges only counted while enabled, so power-up glitches are ignored
			assign rise_evt[g] = ctrl_q[g][ccr_pkg::CTRL_EN_BIT] & res_sync[g] & ~res_prev_q[g];
			assign fall_evt[g] = ctrl_q[g][ccr_pkg::CTRL_EN_BIT] & ~res_sync[g] & res_prev_q[g];
			// set wins over a same-cycle clear
			assign rise_d = rise_evt[g] | (ctrl_sel[g] & sfr_wr ? sfr_wdata[ccr_pkg::CTRL_RISE_BIT]
				: ctrl_q[g][ccr_pkg::CTRL_RISE_BIT]);
			assign fall_d = fall_evt[g] | (ctrl_sel[g] & sfr_wr ? sfr_wdata[ccr_pkg::CTRL_FALL_BIT]
				: ctrl_q[g][ccr_pkg::CTRL_FALL_BIT]);
			assign ctrl_rd = {ctrl_q[g][ccr_pkg::CTRL_EN_BIT], res_sync[g] & ctrl_q[g][ccr_pkg::CTRL_EN_BIT],
				ctrl_q[g][ccr_pkg::CTRL_RISE_BIT:0]};

			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					ctrl_q[g]     <= ccr_pkg::CTRL_RESET;
					mode_q[g]     <= ccr_pkg::MODE_RESET;
					res_prev_q[g] <= 1'b0;
				end else begin
					res_prev_q[g] <= res_sync[g];
					ctrl_q[g][ccr_pkg::CTRL_RISE_BIT] <= rise_d;
					ctrl_q[g][ccr_pkg::CTRL_FALL_BIT] <= fall_d;
					ctrl_q[g][ccr_pkg::CTRL_OUT_BIT] <= 1'b0;
					if (ctrl_sel[g] && sfr_wr) begin
						ctrl_q[g][ccr_pkg::CTRL_EN_BIT] <= sfr_wdata[ccr_pkg::CTRL_EN_BIT];
						ctrl_q[g][3:0] <= sfr_wdata[3:0];
					end
					if (mode_sel[g] && sfr_wr) begin
						mode_q[g] <= sfr_wdata & ccr_pkg::MODE_WMASK;
					end
				end
			end

			assign cmp_enable[g]              = ctrl_q[g][ccr_pkg::CTRL_EN_BIT];
			assign pos_hysteresis_sel[2*g+:2] = ctrl_q[g][ccr_pkg::CTRL_HYP_LSB+:2];
			assign neg_hysteresis_sel[2*g+:2] = ctrl_q[g][ccr_pkg::CTRL_HYN_LSB+:2];
			assign response_time_sel[2*g+:2]  = mode_q[g][ccr_pkg::MODE_MD_LSB+:2];
			assign cmp_pin_out[g] = ctrl_q[g][ccr_pkg::CTRL_EN_BIT] & res_sync[g];
			assign cmp_irq[g] = cmp_irq_global_en[g] &
				((mode_q[g][ccr_pkg::MODE_RIE_BIT] & ctrl_q[g][ccr_pkg::CTRL_RISE_BIT]) |
				 (mode_q[g][ccr_pkg::MODE_FIE_BIT] & ctrl_q[g][ccr_pkg::CTRL_FALL_BIT]));

			// read data mux contribution; the two address decodes never overlap
			assign rdata_parts[g] = mode_sel[g] ? mode_q[g] : (ctrl_sel[g] ? ctrl_rd : 8'h00);

			// the read port is registered, so read-back checks look one edge later
			property p_rd_enable;
				@(posedge mclk) disable iff (!reset_n)
				(ctrl_sel[g] && sfr_rd) |=> (sfr_rdata[ccr_pkg::CTRL_EN_BIT] == $past(cmp_enable[g]));
			endproperty
			a_rd_enable: assert property (p_rd_enable) else $error("enable bit not read back");

			property p_rd_result;
				@(posedge mclk) disable iff (!reset_n)
				(ctrl_sel[g] && sfr_rd) |=> (sfr_rdata[ccr_pkg::CTRL_OUT_BIT] == $past(res_sync[g] && cmp_enable[g]));
			endproperty
			a_rd_result: assert property (p_rd_result) else $error("result bit not read back");

			property p_rd_mode_zero;
				@(posedge mclk) disable iff (!reset_n)
				(mode_sel[g] && sfr_rd) |=> ((sfr_rdata & ~ccr_pkg::MODE_WMASK) == 8'h00);
			endproperty
			a_rd_mode_zero: assert property (p_rd_mode_zero) else $error("unused mode bits read set");

			property p_rd_mode_time;
				@(posedge mclk) disable iff (!reset_n)
				(mode_sel[g] && sfr_rd) |=> (sfr_rdata[ccr_pkg::MODE_MD_LSB+:2] == $past(response_time_sel[2*g+:2]));
			endproperty
			a_rd_mode_time: assert property (p_rd_mode_time) else $error("response time not read back");

			property p_pos_hys_write;
				@(posedge mclk) disable iff (!reset_n)
				(ctrl_sel[g] && sfr_wr) |=> (pos_hysteresis_sel[2*g+:2] == $past(sfr_wdata[ccr_pkg::CTRL_HYP_LSB+:2]));
			endproperty
			a_pos_hys_write: assert property (p_pos_hys_write) else $error("positive hysteresis not written");

			property p_neg_hys_write;
				@(posedge mclk) disable iff (!reset_n)
				(ctrl_sel[g] && sfr_wr) |=> (neg_hysteresis_sel[2*g+:2] == $past(sfr_wdata[ccr_pkg::CTRL_HYN_LSB+:2]));
			endproperty
			a_neg_hys_write: assert property (p_neg_hys_write) else $error("negative hysteresis not written");

			property p_ctrl_hold;
				@(posedge mclk) disable iff (!reset_n)
				!(ctrl_sel[g] && sfr_wr) |=> ($stable(cmp_enable[g]) && $stable(pos_hysteresis_sel[2*g+:2])
					&& $stable(neg_hysteresis_sel[2*g+:2]));
			endproperty
			a_ctrl_hold: assert property (p_ctrl_hold) else $error("control field moved without a write");

			property p_mode_hold;
				@(posedge mclk) disable iff (!reset_n)
				!(mode_sel[g] && sfr_wr) |=> $stable(mode_q[g]);
			endproperty
			a_mode_hold: assert property (p_mode_hold) else $error("mode moved without a write");

			property p_irq_en_write;
				@(posedge mclk) disable iff (!reset_n)
				(mode_sel[g] && sfr_wr) |=> ((mode_q[g][ccr_pkg::MODE_RIE_BIT] == $past(sfr_wdata[ccr_pkg::MODE_RIE_BIT]))
					&& (mode_q[g][ccr_pkg::MODE_FIE_BIT] == $past(sfr_wdata[ccr_pkg::MODE_FIE_BIT])));
			endproperty
			a_irq_en_write: assert property (p_irq_en_write) else $error("edge enables not written");

			property p_rise_flag;
				@(posedge mclk) disable iff (!reset_n)
				rise_evt[g] |=> ctrl_q[g][ccr_pkg::CTRL_RISE_BIT];
			endproperty
			a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set");

			property p_fall_flag;
				@(posedge mclk) disable iff (!reset_n)
				fall_evt[g] |=> ctrl_q[g][ccr_pkg::CTRL_FALL_BIT];
			endproperty
			a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set");

			property p_fall_sticky;
				@(posedge mclk) disable iff (!reset_n)
				(ctrl_q[g][ccr_pkg::CTRL_FALL_BIT] && !(ctrl_sel[g] && sfr_wr)) |=> ctrl_q[g][ccr_pkg::CTRL_FALL_BIT];
			endproperty
			a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag dropped");

			// a comparator that is off may glitch while it powers up, so it must not flag
			property p_quiet_off;
				@(posedge mclk) disable iff (!reset_n)
				(!cmp_enable[g] && !(ctrl_sel[g] && sfr_wr)) |=>
					($stable(ctrl_q[g][ccr_pkg::CTRL_RISE_BIT]) && $stable(ctrl_q[g][ccr_pkg::CTRL_FALL_BIT]));
			endproperty
			a_quiet_off: assert property (p_quiet_off) else $error("flag moved while disabled");

			property p_irq_rise;
				@(posedge mclk) disable iff (!reset_n)
				(cmp_irq_global_en[g] && mode_q[g][ccr_pkg::MODE_RIE_BIT] && ctrl_q[g][ccr_pkg::CTRL_RISE_BIT]) |-> cmp_irq[g];
			endproperty
			a_irq_rise: assert property (p_irq_rise) else $error("rise interrupt missing");

			property p_irq_fall;
				@(posedge mclk) disable iff (!reset_n)
				(cmp_irq_global_en[g] && mode_q[g][ccr_pkg::MODE_FIE_BIT] && ctrl_q[g][ccr_pkg::CTRL_FALL_BIT]) |-> cmp_irq[g];
			endproperty
			a_irq_fall: assert property (p_irq_fall) else $error("fall interrupt missing");

			property p_irq_global;
				@(posedge mclk) disable iff (!reset_n)
				!cmp_irq_global_en[g] |-> !cmp_irq[g];
			endproperty
			a_irq_global: assert property (p_irq_global) else $error("interrupt without extended enable");

			property p_pin_follows;
				@(posedge mclk) disable iff (!reset_n)
				cmp_enable[g] |-> (cmp_pin_out[g] == res_sync[g]);
			endproperty
			a_pin_follows: assert property (p_pin_follows) else $error("pin does not follow result");
		end
	endgenerate

	assign rdata_d   = rdata_parts[0] | rdata_parts[1] | rdata_parts[2];
	assign sfr_rdata = rdata_q;

	// registered read data; unmapped reads return zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// a rising edge on an enabled comparator sets its flag next cycle
	property p_rise_sets;
		@(posedge mclk) disable iff (!reset_n)
		rise_evt[0] |=> ctrl_q[0][ccr_pkg::CTRL_RISE_BIT];
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise flag not set");

	property p_fall_sets;
		@(posedge mclk) disable iff (!reset_n)
		fall_evt[0] |=> ctrl_q[0][ccr_pkg::CTRL_FALL_BIT];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall flag not set");

	property p_set_beats_clear;
		@(posedge mclk) disable iff (!reset_n)
		(rise_evt[2] && ctrl_sel[2] && sfr_wr && !sfr_wdata[5]) |=> ctrl_q[2][5];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set");

	property p_sticky;
		@(posedge mclk) disable iff (!reset_n)
		(ctrl_q[0][5] && !(ctrl_sel[0] && sfr_wr)) |=> ctrl_q[0][5];
	endproperty
	a_sticky: assert property (p_sticky) else $error("rise flag dropped");

	property p_pin_low_off;
		@(posedge mclk) disable iff (!reset_n)
		!cmp_enable[1] |-> !cmp_pin_out[1];
	endproperty
	a_pin_low_off: assert property (p_pin_low_off) else $error("disabled pin not low");

	property p_irq_gate;
		@(posedge mclk) disable iff (!reset_n)
		cmp_irq[0] |-> (cmp_irq_global_en[0] && (mode_q[0][5] || mode_q[0][4]));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

	property p_mode_unused_zero;
		@(posedge mclk) disable iff (!reset_n)
		(mode_q[2] & ~ccr_pkg::MODE_WMASK) == 8'h00;
	endproperty
	a_mode_unused_zero: assert property (p_mode_unused_zero) else $error("unused mode bits set");

	property p_mode_write;
		@(posedge mclk) disable iff (!reset_n)
		(mode_sel[1] && sfr_wr) |=> (response_time_sel[3:2] == $past(sfr_wdata[1:0]));
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("response time not written");

	property p_enable_write;
		@(posedge mclk) disable iff (!reset_n)
		(ctrl_sel[2] && sfr_wr) |=> (cmp_enable[2] == $past(sfr_wdata[7]));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not written");

	property p_edge_from_sync;
		@(posedge mclk) disable iff (!reset_n)
		(cmp_enable[0] && $rose(res_sync[0])) |=> (ctrl_q[0][ccr_pkg::CTRL_RISE_BIT]
			&& (cmp_irq[0] || !(cmp_irq_global_en[0] && mode_q[0][ccr_pkg::MODE_RIE_BIT])));
	endproperty
	a_edge_from_sync: assert property (p_edge_from_sync) else $error("edge missed");

	// unmapped reads return zero so software probing other pages sees a clean bus
	property p_unmapped_read;
		@(posedge mclk) disable iff (!reset_n)
		(sfr_rd && !sfr_hit) |=> (sfr_rdata == 8'h00);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_rdata_hold;
		@(posedge mclk) disable iff (!reset_n)
		!sfr_rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule : ccr_regs

// >>> ccr_pkg.sv
// constants for the comparator control register bank
package ccr_pkg;
	localparam int          NUM_CMP          = 3;
	localparam logic [7:0]  CTRL_ADDR        = 8'h88;
	localparam logic [7:0]  MODE_ADDR        = 8'h89;
	localparam logic [7:0]  PAGE_CMP0        = 8'h01;
	localparam int          CTRL_EN_BIT      = 7;
	localparam int          CTRL_OUT_BIT     = 6;
	localparam int          CTRL_RISE_BIT    = 5;
	localparam int          CTRL_FALL_BIT    = 4;
	localparam int          CTRL_HYP_LSB     = 2;
	localparam int          CTRL_HYN_LSB     = 0;
	localparam int          MODE_RIE_BIT     = 5;
	localparam int          MODE_FIE_BIT     = 4;
	localparam int          MODE_MD_LSB      = 0;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic [7:0]  MODE_RESET       = 8'h02;
	localparam logic [7:0]  MODE_WMASK       = 8'h33;
endpackage : ccr_pkg

// >>> ccr_sync.sv
// three-stage synchroniser with agreement filter for one comparator output
`timescale 1ns/1ps
module ccr_sync (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic async_in,
	output logic      level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// s1 feeds only s2; level moves only when s2 and s3 agree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule : ccr_sync

// >>> ccr_cpu_model.sv
// processor-side model that runs single-byte cycles on the special function register bus
`timescale 1ns/1ps
module ccr_cpu_model (
	input  wire logic       mclk,
	output logic      [7:0] sfr_addr,
	output logic      [7:0] sfr_page,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic      [7:0] sfr_wdata,
	input  wire logic [7:0] sfr_rdata
);
	initial begin
		sfr_addr = 8'h00;
		sfr_page = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	// one access, entered just after an edge; a spare edge keeps strobes from retoggling in one step
	task automatic cycle(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, input logic w,
		output logic [7:0] q);
		sfr_addr = a;
		sfr_page = p;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		@(posedge mclk);
		#1;
		q = sfr_rdata;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		// a released bus shows no stale value
		sfr_addr = ~a;
		sfr_wdata = ~d;
		@(posedge mclk);
		#1;
	endtask : cycle
	// input pins are assumed set up as analog inputs, outside this bus
	task automatic settle();
		repeat (1000) @(posedge mclk); // power-up wait after enabling
		#1;
	endtask : settle
endmodule : ccr_cpu_model

// >>> testbench.sv
// self-checking bench for the comparator control register bank
`timescale 1ns/1ps
module testbench;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  sfr_addr, sfr_page, sfr_wdata, sfr_rdata, q;
	logic        sfr_wr, sfr_rd, sfr_hit;
	logic        hit_seen = 1'b0;
	logic [2:0]  cmp_raw = 3'b000, cmp_irq_global_en = 3'b000, cmp_enable, cmp_pin_out, cmp_irq;
	logic [5:0]  pos_hysteresis_sel, neg_hysteresis_sel, response_time_sel;
	int          n_mismatch = 0;
	int          compares = 0;
	// expected hit, address, page, write data, expected read back
	logic [35:0] rows [8] = '{36'h188018F8F, 36'h188024A0A, 36'h188038585, 36'h18901FF33,
		36'h189020000, 36'h18903C101, 36'h08A01FF00, 36'h08804FF00};
	always #5 mclk = ~mclk;
	// hit as decoded at the edge that takes each access
	always @(posedge mclk) begin
		if (sfr_wr || sfr_rd) hit_seen <= sfr_hit;
	end
	ccr_regs dut (.mclk, .reset_n, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
		.cmp_raw, .cmp_irq_global_en, .cmp_enable, .pos_hysteresis_sel, .neg_hysteresis_sel,
		.response_time_sel, .cmp_pin_out, .cmp_irq);
	ccr_cpu_model cpu (.mclk, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata);
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin
	task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		cpu.cycle(a, p, d, 1'b1, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
		cpu.cycle(a, p, 8'h00, 1'b0, q);
		chk_reg(q, e);
	endtask : rd_chk
	task automatic pause();
		repeat (8) @(posedge mclk);
		#1;
	endtask : pause
	task automatic give_verdict();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][31:24], rows[i][23:16], rows[i][15:8]);
			rd_chk(rows[i][31:24], rows[i][23:16], rows[i][7:0]);
			chk_pin({7'h00, hit_seen}, {7'h00, rows[i][32]});
		end
		chk_pin({5'h00, cmp_enable}, 8'h05);
		chk_pin({2'h0, pos_hysteresis_sel}, 8'h1B);
		chk_pin({2'h0, neg_hysteresis_sel}, 8'h1B);
		chk_pin({2'h0, response_time_sel}, 8'h13);
		$display("test register table done");
		wr(8'h88, 8'h01, 8'h80);
		wr(8'h89, 8'h01, 8'h30);
		cmp_irq_global_en = 3'b001;
		cpu.settle();
		cmp_raw = 3'b011;
		pause();
		rd_chk(8'h88, 8'h01, 8'hE0);
		rd_chk(8'h88, 8'h02, 8'h0A);
		chk_pin({5'h00, cmp_pin_out}, 8'h01);
		chk_pin({5'h00, cmp_irq}, 8'h01);
		cmp_raw = 3'b000;
		pause();
		rd_chk(8'h88, 8'h01, 8'hB0);
		wr(8'h88, 8'h01, 8'h80);
		rd_chk(8'h88, 8'h01, 8'h80);
		chk_pin({5'h00, cmp_irq}, 8'h00);
		$display("test edge flags done");
		cmp_irq_global_en = 3'b000;
		cmp_raw = 3'b001;
		pause();
		chk_pin({5'h00, cmp_irq}, 8'h00);
		cmp_irq_global_en = 3'b001;
		wr(8'h89, 8'h01, 8'h10);
		chk_pin({5'h00, cmp_irq}, 8'h00);
		wr(8'h89, 8'h01, 8'h20);
		chk_pin({5'h00, cmp_irq}, 8'h01);
		wr(8'h88, 8'h01, 8'h00);
		chk_pin({5'h00, cmp_pin_out}, 8'h00);
		$display("test interrupt gating done");
		// the write lands on the edge at which the synchronised rise is flagged
		cmp_raw = 3'b101;
		repeat (4) @(posedge mclk);
		#1;
		wr(8'h88, 8'h03, 8'h84);
		rd_chk(8'h88, 8'h03, 8'hE4);
		$display("test set beats clear done");
		reset_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		rd_chk(8'h89, 8'h01, 8'h02);
		rd_chk(8'h88, 8'h03, 8'h00);
		chk_pin({2'h0, response_time_sel}, 8'h2A);
		$display("test reset done");
		give_verdict();
	end
	// the run needs about 1100 cycles; the limit leaves ample slack
	initial begin
		#50000;
		n_mismatch++;
		give_verdict();
	end
endmodule : testbench
